/* File: hdl/pe2_pkg.sv */
// constants and types shared by the two-bit processing slice
package pe2_pkg;

	// ----------------------------------------------------------------
	// data path shape
	// ----------------------------------------------------------------
	localparam int unsigned SLICE_W = 2;
	localparam int unsigned NUM_SCRATCH = 11;
	localparam logic [3:0] TEMP_IDX = 4'ha;
	localparam logic [3:0] LAST_GEN_IDX = 4'h9;

	// ----------------------------------------------------------------
	// microfunction code fields
	// ----------------------------------------------------------------
	localparam int unsigned FCLS_HI = 6;
	localparam int unsigned FCLS_LO = 4;
	localparam int unsigned RSEL_HI = 3;
	localparam int unsigned RSEL_LO = 0;
	localparam logic [2:0] FCLS_ADD = 3'h0;
	localparam logic [2:0] FCLS_ADDR = 3'h1;
	localparam logic [2:0] FCLS_AND = 3'h4;

	// upper three register-select bits of the result/temporary pairs
	localparam logic [2:0] RPAIR_G1 = 3'h6;
	localparam logic [2:0] RPAIR_G2 = 3'h5;
	localparam logic [2:0] RPAIR_G3 = 3'h7;

	// ----------------------------------------------------------------
	// reset and constant values
	// ----------------------------------------------------------------
	localparam logic [SLICE_W-1:0] WORD_ZERO = 2'h0;
	localparam logic [SLICE_W-1:0] WORD_ONES = 2'h3;

	typedef enum logic [1:0] {
		RG_I,
		RG_II,
		RG_III
	} pe2_rgrp_t;

	typedef enum logic [1:0] {
		A_MEM,
		A_SCR,
		A_ACC
	} pe2_amux_t;

	typedef enum logic [1:0] {
		B_IO,
		B_ACC,
		B_LIT
	} pe2_bmux_t;

endpackage

/* File: hdl/pe2_slice.sv */
// two-bit cascadable processing slice: operand muxes, alu, result register, scratchpad
//
// How it works
// - upper three code bits pick operation class, lower four pick registers
// - first operand mux picks memory input, scratchpad register or result register
// - second operand mux picks io input, result register or mask/literal bus
// - eleven scratchpad registers, ten general plus temporary, reach alu via first mux
// - each result goes to result register, scratchpad register or both
// - two lookahead outputs plus shift fill input and low-bit shift output
// - mask all ones includes the result register, all zeros removes it
// - logical operations drive carry with word OR of result bits and carry in
// - address latch holds memory address and drives three-state address bus
// - data output bus carries result register copy, three-state
// - memory and io input buses are two bits each
// - class 0 group I: reg plus (result AND mask) plus carry to reg and result
// - with result selected and mask ones it shifts left; mask zeros increments
// - class 0 group II: memory plus (result AND mask) plus carry to selected
// - class 0 group III: shift selected right, low bit out, fill high bit
// - class 1 group I: latch gets mask OR reg; reg gets reg plus mask plus carry
// - class 1 group I, mask zeros: latch gets reg, reg adds carry
// - class 1 group I, mask ones: latch all ones, reg minus one plus carry
// - class 1 group II: latch gets mask OR memory; selected gets memory plus mask plus carry
// - class 1 group II, mask zeros: latch gets memory, selected gets memory plus carry
// - class 1 group II, mask ones: latch all ones, memory minus one plus carry
// - carry output floats on right shifts and in reset; shift output driven only on right shifts
// - address and data bus enables follow their low enable inputs one clock edge later
// - codes 0-9 are general registers; pairs 110x, 101x, 111x are groups I, II, III
module pe2_slice (
	input wire logic core_clk_i,
	input wire logic rst_i,
	input wire logic [6:0] microfunction_code_bus_i,
	input wire logic [1:0] mem_data_i,
	input wire logic [1:0] io_data_i,
	input wire logic [1:0] mask_literal_i,
	input wire logic carry_input_n_i,
	input wire logic shift_fill_input_n_i,
	input wire logic address_output_enable_n_i,
	input wire logic data_output_enable_n_i,
	output logic [1:0] address_bus_o,
	output logic address_bus_oe_n_o,
	output logic [1:0] data_bus_o,
	output logic data_bus_oe_n_o,
	output logic ripple_carry_output_n_o,
	output logic ripple_carry_oe_n_o,
	output logic low_bit_shift_output_n_o,
	output logic low_bit_shift_oe_n_o,
	output logic lookahead_x_o,
	output logic lookahead_y_o
);

	// ----------------------------------------------------------------
	// arithmetic helper
	// ----------------------------------------------------------------
	function automatic logic [2:0] pe2_add(input logic [1:0] a, input logic [1:0] b,
			input logic c);
		logic [2:0] s;
		s = {1'b0, a} + {1'b0, b} + {2'h0, c};
		return s;
	endfunction

	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	logic [1:0] result_register_q;
	logic [1:0] result_register_d;
	logic [1:0] memory_address_latch_q;
	logic [1:0] memory_address_latch_d;
	logic [1:0] scratch_q [pe2_pkg::NUM_SCRATCH];
	logic [1:0] scratch_d [pe2_pkg::NUM_SCRATCH];
	logic carry_n_q;
	logic carry_n_d;
	logic carry_oe_n_q;
	logic carry_oe_n_d;
	logic shift_n_q;
	logic shift_n_d;
	logic shift_oe_n_q;
	logic shift_oe_n_d;
	logic x_q;
	logic x_d;
	logic y_q;
	logic y_d;
	logic addr_oe_n_q;
	logic data_oe_n_q;

	// ----------------------------------------------------------------
	// decode
	// ----------------------------------------------------------------
	logic [2:0] fcls;
	logic [3:0] rsel;
	pe2_pkg::pe2_rgrp_t rgrp;
	logic tgt_is_acc;
	logic [3:0] tgt_idx;
	logic [1:0] tgt_val;
	logic carry_in;

	always_comb begin
		fcls = microfunction_code_bus_i[pe2_pkg::FCLS_HI:pe2_pkg::FCLS_LO];
		rsel = microfunction_code_bus_i[pe2_pkg::RSEL_HI:pe2_pkg::RSEL_LO];
		carry_in = ~carry_input_n_i;
		tgt_is_acc = 1'b0;
		tgt_idx = pe2_pkg::TEMP_IDX;
		rgrp = pe2_pkg::RG_I;
		if (rsel <= pe2_pkg::LAST_GEN_IDX) begin
			tgt_idx = rsel;
		end else begin
			tgt_is_acc = rsel[0];
			case (rsel[3:1])
				pe2_pkg::RPAIR_G1: rgrp = pe2_pkg::RG_I;
				pe2_pkg::RPAIR_G2: rgrp = pe2_pkg::RG_II;
				pe2_pkg::RPAIR_G3: rgrp = pe2_pkg::RG_III;
				default: rgrp = pe2_pkg::RG_I;
			endcase
		end
		tgt_val = tgt_is_acc ? result_register_q : scratch_q[tgt_idx];
	end

	// ----------------------------------------------------------------
	// operand multiplexers and alu
	// ----------------------------------------------------------------
	pe2_pkg::pe2_amux_t a_sel;
	pe2_pkg::pe2_bmux_t b_sel;
	logic [1:0] a_op;
	logic [1:0] b_op;
	logic [2:0] sum;
	logic [1:0] gen;
	logic [1:0] prop;

	always_comb begin
		a_sel = tgt_is_acc ? pe2_pkg::A_ACC : pe2_pkg::A_SCR;
		b_sel = pe2_pkg::B_ACC;
		if (rgrp == pe2_pkg::RG_II && rsel > pe2_pkg::LAST_GEN_IDX) begin
			a_sel = pe2_pkg::A_MEM;
		end
		if (fcls == pe2_pkg::FCLS_ADDR) begin
			b_sel = pe2_pkg::B_LIT;
		end else if (fcls == pe2_pkg::FCLS_ADD && rgrp == pe2_pkg::RG_III
				&& rsel > pe2_pkg::LAST_GEN_IDX) begin
			b_sel = pe2_pkg::B_IO;
		end
		case (a_sel)
			pe2_pkg::A_MEM: a_op = mem_data_i;
			pe2_pkg::A_ACC: a_op = result_register_q;
			pe2_pkg::A_SCR: a_op = scratch_q[tgt_idx];
			default: a_op = pe2_pkg::WORD_ZERO;
		endcase
		case (b_sel)
			pe2_pkg::B_IO: b_op = io_data_i & mask_literal_i;
			pe2_pkg::B_ACC: b_op = result_register_q & mask_literal_i;
			pe2_pkg::B_LIT: b_op = mask_literal_i;
			default: b_op = pe2_pkg::WORD_ZERO;
		endcase
		sum = pe2_add(a_op, b_op, carry_in);
		gen = a_op & b_op;
		prop = a_op | b_op;
	end

	// ----------------------------------------------------------------
	// next state of registers and cascade outputs
	// ----------------------------------------------------------------
	always_comb begin
		result_register_d = result_register_q;
		memory_address_latch_d = memory_address_latch_q;
		scratch_d = scratch_q;
		carry_n_d = ~carry_in;
		carry_oe_n_d = 1'b0;
		shift_n_d = 1'b1;
		shift_oe_n_d = 1'b1;
		x_d = gen[1] | (prop[1] & gen[0]);
		y_d = prop[1] & prop[0];
		case (fcls)
			pe2_pkg::FCLS_ADD: begin
				if (rgrp == pe2_pkg::RG_III && rsel > pe2_pkg::LAST_GEN_IDX) begin
					// right shift: carry pin floats, shift pin drives old low bit
					carry_oe_n_d = 1'b1;
					shift_oe_n_d = 1'b0;
					shift_n_d = ~tgt_val[0];
					if (tgt_is_acc) begin
						result_register_d = {~shift_fill_input_n_i, tgt_val[1]};
					end else begin
						scratch_d[tgt_idx] = {~shift_fill_input_n_i, tgt_val[1]};
					end
				end else begin
					carry_n_d = ~sum[2];
					if (rgrp == pe2_pkg::RG_II && rsel > pe2_pkg::LAST_GEN_IDX) begin
						if (tgt_is_acc) begin
							result_register_d = sum[1:0];
						end else begin
							scratch_d[tgt_idx] = sum[1:0];
						end
					end else begin
						// with the result register as operand and mask all ones this doubles it
						result_register_d = sum[1:0];
						if (!tgt_is_acc) begin
							scratch_d[tgt_idx] = sum[1:0];
						end
					end
				end
			end
			pe2_pkg::FCLS_ADDR: begin
				if (rgrp != pe2_pkg::RG_III || rsel <= pe2_pkg::LAST_GEN_IDX) begin
					carry_n_d = ~sum[2];
					// mask zeros passes the operand, mask ones forces all ones
					memory_address_latch_d = a_op | mask_literal_i;
					if (tgt_is_acc) begin
						result_register_d = sum[1:0];
					end else begin
						scratch_d[tgt_idx] = sum[1:0];
					end
				end
			end
			pe2_pkg::FCLS_AND: begin
				if (rgrp != pe2_pkg::RG_III || rsel <= pe2_pkg::LAST_GEN_IDX) begin
					carry_n_d = ~(carry_in | (|(a_op & b_op)));
					if (tgt_is_acc) begin
						result_register_d = a_op & b_op;
					end else begin
						scratch_d[tgt_idx] = a_op & b_op;
					end
				end
			end
			default: begin
				carry_n_d = ~carry_in;
			end
		endcase
	end

	// ----------------------------------------------------------------
	// registers: every update of a microfunction lands on one edge
	// ----------------------------------------------------------------
	always_ff @(posedge core_clk_i or posedge rst_i) begin
		if (rst_i) begin
			result_register_q <= pe2_pkg::WORD_ZERO;
			memory_address_latch_q <= pe2_pkg::WORD_ZERO;
			for (int i = 0; i < pe2_pkg::NUM_SCRATCH; i++) begin
				scratch_q[i] <= pe2_pkg::WORD_ZERO;
			end
			carry_n_q <= 1'b1;
			carry_oe_n_q <= 1'b1;
			shift_n_q <= 1'b1;
			shift_oe_n_q <= 1'b1;
			x_q <= 1'b0;
			y_q <= 1'b0;
			addr_oe_n_q <= 1'b1;
			data_oe_n_q <= 1'b1;
		end else begin
			result_register_q <= result_register_d;
			memory_address_latch_q <= memory_address_latch_d;
			scratch_q <= scratch_d;
			carry_n_q <= carry_n_d;
			carry_oe_n_q <= carry_oe_n_d;
			shift_n_q <= shift_n_d;
			shift_oe_n_q <= shift_oe_n_d;
			x_q <= x_d;
			y_q <= y_d;
			addr_oe_n_q <= address_output_enable_n_i;
			data_oe_n_q <= data_output_enable_n_i;
		end
	end

	// ----------------------------------------------------------------
	// outputs
	// ----------------------------------------------------------------
	assign address_bus_o = memory_address_latch_q;
	assign address_bus_oe_n_o = addr_oe_n_q;
	assign data_bus_o = result_register_q;
	assign data_bus_oe_n_o = data_oe_n_q;
	assign ripple_carry_output_n_o = carry_n_q;
	assign ripple_carry_oe_n_o = carry_oe_n_q;
	assign low_bit_shift_output_n_o = shift_n_q;
	assign low_bit_shift_oe_n_o = shift_oe_n_q;
	assign lookahead_x_o = x_q;
	assign lookahead_y_o = y_q;

endmodule

/* File: tb/pe2_assertions.sv */
// port checks for the processing slice
module pe2_assertions (
	input wire logic core_clk_i,
	input wire logic rst_i,
	input wire logic [6:0] microfunction_code_bus_i,
	input wire logic [1:0] mem_data_i,
	input wire logic [1:0] mask_literal_i,
	input wire logic carry_input_n_i,
	input wire logic shift_fill_input_n_i,
	input wire logic address_output_enable_n_i,
	input wire logic data_output_enable_n_i,
	input wire logic [1:0] address_bus_o,
	input wire logic address_bus_oe_n_o,
	input wire logic [1:0] data_bus_o,
	input wire logic data_bus_oe_n_o,
	input wire logic ripple_carry_output_n_o,
	input wire logic ripple_carry_oe_n_o,
	input wire logic low_bit_shift_output_n_o,
	input wire logic low_bit_shift_oe_n_o
);
	logic [6:0] f;
	logic [1:0] mk_or, s_mk, and_v;
	logic [2:0] s_add;
	logic shr, ci;
	assign f = microfunction_code_bus_i;
	assign ci = ~carry_input_n_i;
	assign shr = f[6:4] == 3'h0 && f[3:1] == 3'h7;
	assign mk_or = mem_data_i | mask_literal_i;
	assign s_mk = mem_data_i + mask_literal_i + {1'h0, ci};
	assign and_v = mem_data_i & data_bus_o & mask_literal_i;
	assign s_add = {1'h0, mem_data_i} + {1'h0, data_bus_o & mask_literal_i} + {2'h0, ci};
	default clocking @(posedge core_clk_i); endclocking
	default disable iff (rst_i);
	// ----
	// microfunction effects
	// ----
	sequence s_shift_ac;
		shr && f[0];
	endsequence
	sequence s_mem_group;
		f[6:4] == 3'h1 && f[3:1] == 3'h5;
	endsequence
	a_addr_oe_lag: assert property (address_bus_oe_n_o == $past(address_output_enable_n_i))
		else $error("address enable not one edge behind");
	a_data_oe_lag: assert property (data_bus_oe_n_o == $past(data_output_enable_n_i))
		else $error("data enable not one edge behind");
	a_cascade_oe: assert property (1'h1 |=> ripple_carry_oe_n_o == $past(shr)
		&& low_bit_shift_oe_n_o == !$past(shr)) else $error("cascade pin enables wrong");
	a_shift_right: assert property (s_shift_ac |=> low_bit_shift_output_n_o ==
		!$past(data_bus_o[0]) && data_bus_o == {!$past(shift_fill_input_n_i), $past(data_bus_o[1])})
		else $error("right shift wrong");
	a_add_mem: assert property (f == 7'h0b |=> {!ripple_carry_output_n_o, data_bus_o} == $past(s_add))
		else $error("memory add wrong");
	a_and_carry: assert property (f == 7'h4b |=> data_bus_o == $past(and_v) &&
		!ripple_carry_output_n_o == ($past(ci) || |$past(and_v))) else $error("word or carry wrong");
	a_mar_or_mem: assert property (s_mem_group |=> address_bus_o == $past(mk_or))
		else $error("latch not mask or memory");
	a_mem_sum: assert property (s_mem_group ##0 f[0] |=> data_bus_o == $past(s_mk))
		else $error("memory plus mask wrong");
	a_mar_ones: assert property (f[6:4] == 3'h1 && (!f[3] || !f[1]) && mask_literal_i == 2'h3
		|=> address_bus_o == 2'h3) else $error("latch not all ones");
endmodule

/* File: tb/pe2_neighbour.sv */
// neighbouring slices: cascade inputs and pulled-up three-state cascade wires
module pe2_neighbour (
	input wire logic carry_i,
	input wire logic fill_i,
	input wire logic carry_n_i,
	input wire logic carry_oe_n_i,
	input wire logic shift_n_i,
	input wire logic shift_oe_n_i,
	output logic carry_n_o,
	output logic fill_n_o,
	output logic carry_wire_o,
	output logic shift_wire_o
);
	assign carry_n_o = ~carry_i;
	assign fill_n_o = ~fill_i;
	// a released pin floats to the pull-up level
	assign carry_wire_o = carry_oe_n_i ? 1'h1 : carry_n_i;
	assign shift_wire_o = shift_oe_n_i ? 1'h1 : shift_n_i;
endmodule

/* File: tb/test_two_bit_slice_processing_element.sv */
// self-checking bench for the two-bit processing slice
module test_two_bit_slice_processing_element;
	timeunit 1ns;
	timeprecision 1ps;
	logic core_clk_i, rst_i, nb_carry, nb_fill, carry_wire, shift_wire;
	logic [6:0] microfunction_code_bus_i;
	logic [1:0] mem_data_i, io_data_i, mask_literal_i, address_bus_o, data_bus_o;
	logic carry_input_n_i, shift_fill_input_n_i, address_output_enable_n_i;
	logic data_output_enable_n_i, address_bus_oe_n_o, data_bus_oe_n_o;
	logic ripple_carry_output_n_o, ripple_carry_oe_n_o, low_bit_shift_output_n_o;
	logic low_bit_shift_oe_n_o, lookahead_x_o, lookahead_y_o;
	int miscompares, n_tests, cycles;
	pe2_slice dut (.core_clk_i, .rst_i, .microfunction_code_bus_i, .mem_data_i, .io_data_i,
		.mask_literal_i, .carry_input_n_i, .shift_fill_input_n_i, .address_output_enable_n_i,
		.data_output_enable_n_i, .address_bus_o, .address_bus_oe_n_o, .data_bus_o,
		.data_bus_oe_n_o, .ripple_carry_output_n_o, .ripple_carry_oe_n_o,
		.low_bit_shift_output_n_o, .low_bit_shift_oe_n_o, .lookahead_x_o, .lookahead_y_o);
	pe2_neighbour nb (.carry_i(nb_carry), .fill_i(nb_fill), .carry_n_i(ripple_carry_output_n_o),
		.carry_oe_n_i(ripple_carry_oe_n_o), .shift_n_i(low_bit_shift_output_n_o),
		.shift_oe_n_i(low_bit_shift_oe_n_o), .carry_n_o(carry_input_n_i),
		.fill_n_o(shift_fill_input_n_i), .carry_wire_o(carry_wire), .shift_wire_o(shift_wire));
	task automatic check(input string what, input logic [3:0] seen, input logic [3:0] exp);
		n_tests++;
		if (seen !== exp) begin
			miscompares++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic final_report();
		$display("comparisons %0d mismatches %0d", n_tests, miscompares);
		if (miscompares == 0 && n_tests > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	// applies one microfunction at a falling edge, returns one cycle later
	task automatic op(input logic [6:0] f, input logic [1:0] m, input logic [1:0] k, input logic c);
		microfunction_code_bus_i = f;
		mem_data_i = m;
		mask_literal_i = k;
		nb_carry = c;
		@(negedge core_clk_i);
	endtask
	// ----
	// scenarios
	// ----
	task automatic t_reset();
		check("reset", {address_bus_o, data_bus_o}, 4'h0);
		check("idle", {address_bus_oe_n_o, data_bus_oe_n_o, carry_wire, shift_wire}, 4'hf);
	endtask
	task automatic t_load_mem();
		op(7'h0b, 2'h1, 2'h0, 1'h0);
		check("load", {ripple_carry_output_n_o, data_bus_o}, 4'h5);
		op(7'h0b, 2'h2, 2'h3, 1'h1);
		check("sum", {ripple_carry_output_n_o, data_bus_o}, 4'h0);
	endtask
	task automatic t_shift_left();
		op(7'h0b, 2'h1, 2'h0, 1'h0);
		op(7'h0d, 2'h0, 2'h3, 1'h0);
		check("dbl", {ripple_carry_output_n_o, data_bus_o}, 4'h6);
		op(7'h0d, 2'h0, 2'h3, 1'h0);
		check("dbl2", {ripple_carry_output_n_o, data_bus_o}, 4'h0);
		op(7'h0d, 2'h0, 2'h0, 1'h1);
		check("inc", {ripple_carry_output_n_o, data_bus_o}, 4'h5);
	endtask
	task automatic t_pc();
		op(7'h13, 2'h0, 2'h0, 1'h1);
		check("pc0", address_bus_o, 4'h0);
		op(7'h13, 2'h0, 2'h0, 1'h1);
		check("pc1", address_bus_o, 4'h1);
		op(7'h13, 2'h0, 2'h3, 1'h0);
		check("dsm", address_bus_o, 4'h3);
		op(7'h13, 2'h0, 2'h1, 1'h0);
		check("lmi", address_bus_o, 4'h1);
		op(7'h03, 2'h0, 2'h0, 1'h0);
		check("reg", data_bus_o, 4'h2);
		op(7'h0a, 2'h3, 2'h0, 1'h0);
		op(7'h0c, 2'h0, 2'h0, 1'h0);
		check("temp", data_bus_o, 4'h3);
	endtask
	task automatic t_buses();
		address_output_enable_n_i = 1'h0;
		data_output_enable_n_i = 1'h0;
		@(negedge core_clk_i);
		check("abus", {address_bus_oe_n_o, data_bus_oe_n_o, address_bus_o}, 4'h1);
		address_output_enable_n_i = 1'h1;
		@(negedge core_clk_i);
		check("dbus", {address_bus_oe_n_o, data_bus_oe_n_o, data_bus_o}, 4'hb);
		data_output_enable_n_i = 1'h1;
	endtask
	task automatic t_indirect();
		op(7'h1b, 2'h2, 2'h0, 1'h1);
		check("lmm", {address_bus_o, data_bus_o}, 4'hb);
		op(7'h1b, 2'h2, 2'h3, 1'h0);
		check("ldm", {address_bus_o, data_bus_o}, 4'hd);
		op(7'h1b, 2'h1, 2'h2, 1'h0);
		check("mk", {address_bus_o, data_bus_o}, 4'hf);
	endtask
	task automatic t_shift_right();
		op(7'h0b, 2'h1, 2'h0, 1'h0);
		nb_fill = 1'h1;
		op(7'h0f, 2'h0, 2'h0, 1'h0);
		nb_fill = 1'h0;
		check("shr", {data_bus_o, shift_wire, carry_wire}, 4'h9);
		op(7'h0b, 2'h0, 2'h0, 1'h0);
		check("after", {shift_wire, ripple_carry_oe_n_o}, 4'h2);
	endtask
	task automatic t_and_test();
		op(7'h0b, 2'h3, 2'h0, 1'h0);
		op(7'h4b, 2'h2, 2'h3, 1'h0);
		check("and", {ripple_carry_output_n_o, data_bus_o}, 4'h2);
		check("gen", {lookahead_x_o, lookahead_y_o}, 4'h3);
		op(7'h4b, 2'h3, 2'h0, 1'h0);
		check("zero", {ripple_carry_output_n_o, data_bus_o}, 4'h4);
		check("prop", {lookahead_x_o, lookahead_y_o}, 4'h1);
		op(7'h4b, 2'h3, 2'h0, 1'h1);
		check("cin", {ripple_carry_output_n_o, data_bus_o}, 4'h0);
	endtask
	initial begin
		core_clk_i = 1'h0;
		forever #12.5 core_clk_i = ~core_clk_i;
	end
	always @(posedge core_clk_i) begin
		cycles++;
		if (cycles == 400) begin
			miscompares++;
			final_report();
		end
	end
	initial begin
		rst_i = 1'h1;
		microfunction_code_bus_i = 7'h70;
		mem_data_i = 2'h0;
		io_data_i = 2'h0;
		mask_literal_i = 2'h0;
		nb_carry = 1'h0;
		nb_fill = 1'h0;
		address_output_enable_n_i = 1'h1;
		data_output_enable_n_i = 1'h1;
		repeat (16) @(posedge core_clk_i);
		@(negedge core_clk_i);
		rst_i = 1'h0;
		t_reset();
		t_load_mem();
		t_shift_left();
		t_pc();
		t_buses();
		t_indirect();
		t_shift_right();
		t_and_test();
		final_report();
	end
endmodule
bind pe2_slice pe2_assertions chk (.core_clk_i, .rst_i, .microfunction_code_bus_i, .mem_data_i,
	.mask_literal_i, .carry_input_n_i, .shift_fill_input_n_i, .address_output_enable_n_i,
	.data_output_enable_n_i, .address_bus_o, .address_bus_oe_n_o, .data_bus_o, .data_bus_oe_n_o,
	.ripple_carry_output_n_o, .ripple_carry_oe_n_o, .low_bit_shift_output_n_o,
	.low_bit_shift_oe_n_o);
